// [src/fwp_pkg.sv]
// Package: constants, types and helpers of the serial protected memory
// ****************************************************************
// What this block does
// - Opcode 04h clears the write-enable latch, blocking later writes.
// - Status bits 0, 4, 5 read zero, bit 6 reads one; writes ignored.
// - Write-enable flag, status bit 1, is zero after power-up.
// - Status write byte never changes the write-enable flag.
// - Status bit 0, the busy bit, always reads zero.
// - Block-protect bits 3 and 2 are nonvolatile across power cycles.
// - Protect codes: none, 60000h-7FFFFh, 40000h-7FFFFh, whole array.
// - Array write only with latch set and address unprotected.
// - Protect pin ignored unless bit 7 set; then low pin blocks status write.
// - Protect pin never blocks array writes.
// - Opcode 05h shifts out status byte, most significant bit first.
// - Opcode 01h plus byte updates protect bits and counts as a write.
// - Opcode 02h takes three address bytes; low 19 bits used.
// - Write burst goes to next address, wrapping 7FFFFh to 00000h.
// - Write byte committed right after its eighth clock; partial byte lost.
// - Rising chip select ends a write; no data until a new frame.
// - Burst reaching protected address stops incrementing, drops later bytes.
// - Opcode 03h plus address: drive data next clocks, ignore input.
// - Read burst wraps; rising chip select ends it, output high impedance.
// - Opcode 06h sets the write-enable latch; nothing else does.
// - Latch clears when chip select rises after any write-class frame.
// - Unknown opcode: ignore everything until next frame, output off.
// - Modes 0 and 3: sample on rising, drive on falling clock edges.
// ****************************************************************
package fwp_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] FWP_OP_SR_WRITE = 8'h01;
  localparam logic [7:0] FWP_OP_WRITE = 8'h02;
  localparam logic [7:0] FWP_OP_READ = 8'h03;
  localparam logic [7:0] FWP_OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] FWP_OP_SR_READ = 8'h05;
  localparam logic [7:0] FWP_OP_WR_ENABLE = 8'h06;

  // ****************************************************************
  // Array geometry and protected ranges
  // ****************************************************************
  localparam int FWP_AW = 19;
  localparam int FWP_DEPTH = 524288;
  localparam int FWP_ADDR_BYTES = 3;
  localparam logic [18:0] FWP_QUARTER_BASE = 19'h60000;
  localparam logic [18:0] FWP_HALF_BASE = 19'h40000;
  localparam logic [1:0] FWP_BP_NONE = 2'h0;
  localparam logic [1:0] FWP_BP_QUARTER = 2'h1;
  localparam logic [1:0] FWP_BP_HALF = 2'h2;

  // ****************************************************************
  // Status layout, fixed bits and factory defaults
  // ****************************************************************
  typedef struct packed {
    logic pin_en;
    logic one;
    logic [1:0] zero;
    logic [1:0] bp;
    logic write_enable_flag;
    logic busy;
  } fwp_status_t;
  localparam logic FWP_FIXED_ONE = 1'h1;
  localparam logic [1:0] FWP_FIXED_ZERO = 2'h0;
  localparam logic FWP_NOT_BUSY = 1'h0;
  localparam logic [1:0] FWP_BP_DEFAULT = 2'h0;
  localparam logic FWP_PIN_EN_DEFAULT = 1'h0;
  localparam int FWP_SR_PIN_EN = 7;
  localparam int FWP_SR_BP_HI = 3;
  localparam int FWP_SR_BP_LO = 2;

  // ****************************************************************
  // Events passed from the serial clock domain as toggles
  // ****************************************************************
  localparam int FWP_NEV = 4;
  localparam int FWP_EV_WR_ENABLE = 0;
  localparam int FWP_EV_WR_DISABLE = 1;
  localparam int FWP_EV_ARM = 2;
  localparam int FWP_EV_SR_WRITE = 3;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SREAD, ST_SWRITE, ST_IGNORE,
    ST_DONE
  } fwp_state_t;

  function automatic logic fwp_protected(input logic [1:0] bp,
                                         input logic [18:0] addr);
    case (bp)
      FWP_BP_NONE: fwp_protected = 1'b0;
      FWP_BP_QUARTER: fwp_protected = (addr >= FWP_QUARTER_BASE);
      FWP_BP_HALF: fwp_protected = (addr >= FWP_HALF_BASE);
      default: fwp_protected = 1'b1;
    endcase
  endfunction

endpackage

// [src/fwp_core.sv]
// Serial protected memory: command decode, status register and array
`timescale 1ns/100ps
`default_nettype none
module fwp_core
  import fwp_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Hardware protect pin
  input wire logic wp_n
);

  // ****************************************************************
  // Serial clock domain storage
  // ****************************************************************
  logic [7:0] mem [0:FWP_DEPTH-1];
  fwp_state_t state_reg, state_next;
  logic [2:0] bit_reg;
  logic [1:0] abyte_reg;
  logic [6:0] shift_reg;
  logic [18:0] addr_reg;
  logic is_write_reg;
  logic blocked_reg;
  logic [7:0] sr_data_reg;
  logic [FWP_NEV-1:0] tgl_reg = '0;
  fwp_status_t st_s1_reg;
  fwp_status_t st_s2_reg;
  logic [7:0] tx_reg;
  logic so_reg;
  logic so_oe_reg;

  // ****************************************************************
  // System clock domain storage
  // ****************************************************************
  logic [1:0] cs_sync_reg;
  logic cs_prev_reg;
  logic [1:0] wp_sync_reg;
  logic [FWP_NEV-1:0] ev_s1_reg, ev_s2_reg, ev_prev_reg;
  logic we_flag_reg;
  logic arm_reg;
  // Nonvolatile: power-up value only, untouched by rst
  logic [1:0] bp_reg = FWP_BP_DEFAULT;
  logic pin_en_reg = FWP_PIN_EN_DEFAULT;
  fwp_status_t status_reg;

  // ****************************************************************
  // Serial decode
  // ****************************************************************
  wire [7:0] rx_byte = {shift_reg, si};
  wire byte_done = (bit_reg == 3'h7);
  wire last_abyte = (abyte_reg == 2'(FWP_ADDR_BYTES - 1));
  wire [18:0] addr_shifted = {addr_reg[10:0], rx_byte};
  wire [18:0] addr_inc = addr_reg + 19'h1;
  wire we_flag_s = st_s2_reg.write_enable_flag;
  // Pin plays no part here: only latch and block bits guard the array
  wire addr_prot = fwp_protected(st_s2_reg.bp, addr_reg);
  wire write_ok = we_flag_s && !addr_prot && !blocked_reg;
  wire mem_we = (state_reg == ST_WDATA) && byte_done && write_ok;
  wire is_read_state = (state_reg == ST_RDATA) || (state_reg == ST_SREAD);
  wire [7:0] tx_load = (state_reg == ST_RDATA) ? mem[addr_reg] : st_s2_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CMD: begin
        if (byte_done) begin
          case (rx_byte)
            FWP_OP_WR_ENABLE: state_next = ST_DONE;
            FWP_OP_WR_DISABLE: state_next = ST_DONE;
            FWP_OP_SR_READ: state_next = ST_SREAD;
            FWP_OP_SR_WRITE: state_next = ST_SWRITE;
            FWP_OP_WRITE: state_next = ST_ADDR;
            FWP_OP_READ: state_next = ST_ADDR;
            default: state_next = ST_IGNORE;
          endcase
        end
      end
      ST_ADDR: begin
        if (byte_done && last_abyte) begin
          state_next = is_write_reg ? ST_WDATA : ST_RDATA;
        end
      end
      ST_SWRITE: begin
        if (byte_done) begin
          state_next = ST_DONE;
        end
      end
      default: state_next = state_reg;
    endcase
  end

  // Chip select high clears frame state at once, the serial clock may stop
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      state_reg <= ST_CMD;
      bit_reg <= 3'h0;
      abyte_reg <= 2'h0;
      shift_reg <= 7'h00;
      is_write_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_reg + 3'h1;
      shift_reg <= rx_byte[6:0];
      if (state_reg == ST_CMD && byte_done) begin
        is_write_reg <= (rx_byte == FWP_OP_WRITE);
      end
      if (state_reg == ST_ADDR && byte_done) begin
        abyte_reg <= abyte_reg + 2'h1;
      end
      if (state_reg == ST_WDATA && byte_done && !write_ok) begin
        blocked_reg <= 1'b1;
      end
    end
  end

  // Address, array write and status data survive the frame end
  always_ff @(posedge sck) begin
    if (!cs_n) begin
      if (state_reg == ST_ADDR && byte_done) begin
        addr_reg <= addr_shifted;
      end
      if (state_reg == ST_RDATA && byte_done) begin
        addr_reg <= addr_inc;
      end
      if (mem_we) begin
        mem[addr_reg] <= rx_byte;
        addr_reg <= addr_inc;
      end
      if (state_reg == ST_SWRITE && byte_done) begin
        sr_data_reg <= rx_byte;
      end
    end
  end

  // Toggles are never reset so no false event reaches the other domain
  always_ff @(posedge sck) begin
    if (!cs_n && state_reg == ST_CMD && byte_done) begin
      case (rx_byte)
        FWP_OP_WR_ENABLE: begin
          tgl_reg[FWP_EV_WR_ENABLE] <= ~tgl_reg[FWP_EV_WR_ENABLE];
        end
        FWP_OP_WR_DISABLE: begin
          tgl_reg[FWP_EV_WR_DISABLE] <= ~tgl_reg[FWP_EV_WR_DISABLE];
          tgl_reg[FWP_EV_ARM] <= ~tgl_reg[FWP_EV_ARM];
        end
        FWP_OP_SR_WRITE: tgl_reg[FWP_EV_ARM] <= ~tgl_reg[FWP_EV_ARM];
        FWP_OP_WRITE: tgl_reg[FWP_EV_ARM] <= ~tgl_reg[FWP_EV_ARM];
        default: tgl_reg <= tgl_reg;
      endcase
    end
    if (!cs_n && state_reg == ST_SWRITE && byte_done) begin
      tgl_reg[FWP_EV_SR_WRITE] <= ~tgl_reg[FWP_EV_SR_WRITE];
    end
  end

  // Status changes only between frames, so eight opcode edges settle it
  always_ff @(posedge sck) begin
    st_s1_reg <= status_reg;
    st_s2_reg <= st_s1_reg;
  end

  // ****************************************************************
  // Serial output on falling edges
  // ****************************************************************
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (is_read_state) begin
      so_oe_reg <= 1'b1;
      if (bit_reg == 3'h0) begin
        so_reg <= tx_load[7];
        tx_reg <= {tx_load[6:0], 1'b0};
      end else begin
        so_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end else begin
      so_oe_reg <= 1'b0;
    end
  end

  assign so = so_reg;
  assign so_oe = so_oe_reg;

  // ****************************************************************
  // System clock domain: synchronisers and event detect
  // ****************************************************************
  wire [FWP_NEV-1:0] ev = ev_s2_reg ^ ev_prev_reg;
  wire cs_rise = cs_sync_reg[1] && !cs_prev_reg;
  wire wp_low = !wp_sync_reg[1];
  wire sr_locked = pin_en_reg && wp_low;
  wire sr_write = ev[FWP_EV_SR_WRITE] && we_flag_reg && !sr_locked;

  always_ff @(posedge clk) begin
    ev_s1_reg <= tgl_reg;
    ev_s2_reg <= ev_s1_reg;
    wp_sync_reg <= {wp_sync_reg[0], wp_n};
    if (rst) begin
      cs_sync_reg <= 2'h3;
      cs_prev_reg <= 1'b1;
      ev_prev_reg <= ev_s2_reg;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      cs_prev_reg <= cs_sync_reg[1];
      ev_prev_reg <= ev_s2_reg;
    end
  end

  // ****************************************************************
  // Write-enable latch and protect bits
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      we_flag_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else begin
      if (ev[FWP_EV_WR_ENABLE]) begin
        we_flag_reg <= 1'b1;
      end else if (ev[FWP_EV_WR_DISABLE] || (cs_rise && arm_reg)) begin
        we_flag_reg <= 1'b0;
      end
      if (ev[FWP_EV_ARM]) begin
        arm_reg <= 1'b1;
      end else if (cs_rise) begin
        arm_reg <= 1'b0;
      end
    end
  end

  // Only pin enable and block bits take the byte; latch left alone
  always_ff @(posedge clk) begin
    if (sr_write) begin
      pin_en_reg <= sr_data_reg[FWP_SR_PIN_EN];
      bp_reg <= sr_data_reg[FWP_SR_BP_HI:FWP_SR_BP_LO];
    end
  end

  always_ff @(posedge clk) begin
    status_reg.pin_en <= pin_en_reg;
    status_reg.one <= FWP_FIXED_ONE;
    status_reg.zero <= FWP_FIXED_ZERO;
    status_reg.bp <= bp_reg;
    status_reg.write_enable_flag <= we_flag_reg;
    status_reg.busy <= FWP_NOT_BUSY;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_disable_clears;
    @(posedge clk) disable iff (rst)
      ev[FWP_EV_WR_DISABLE] && !ev[FWP_EV_WR_ENABLE] |=>
        !we_flag_reg ##1 !we_flag_reg;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("latch not cleared by disable opcode");

  property p_fixed_bits;
    @(negedge sck) disable iff (cs_n)
      state_reg == ST_SREAD && bit_reg == 3'h0 |->
        tx_load[6] && tx_load[5:4] == 2'h0 && !tx_load[0];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed status bits wrong");

  property p_flag_reset;
    @(posedge clk) rst |=> !we_flag_reg;
  endproperty
  a_flag_reset: assert property (p_flag_reset)
    else $error("latch set after reset");

  property p_sr_keeps_flag;
    @(posedge clk) disable iff (rst)
      sr_write && !ev[FWP_EV_WR_ENABLE] && !ev[FWP_EV_WR_DISABLE] &&
        !cs_rise |=> we_flag_reg == $past(we_flag_reg);
  endproperty
  a_sr_keeps_flag: assert property (p_sr_keeps_flag)
    else $error("status write changed latch");

  property p_array_guard;
    @(posedge sck) disable iff (cs_n)
      mem_we |-> we_flag_s && st_s2_reg.bp != 2'h3 &&
        !(st_s2_reg.bp == 2'h1 && addr_reg >= 19'h60000) &&
        !(st_s2_reg.bp == 2'h2 && addr_reg >= 19'h40000);
  endproperty
  a_array_guard: assert property (p_array_guard)
    else $error("write into protected range");

  property p_pin_lock;
    @(posedge clk) disable iff (rst)
      ev[FWP_EV_SR_WRITE] && pin_en_reg && wp_low |=>
        bp_reg == $past(bp_reg) && pin_en_reg;
  endproperty
  a_pin_lock: assert property (p_pin_lock)
    else $error("status written while pin locked");

  property p_burst_inc;
    @(posedge sck) disable iff (cs_n)
      mem_we |=> addr_reg == $past(addr_reg) + 19'h1;
  endproperty
  a_burst_inc: assert property (p_burst_inc)
    else $error("burst address not advanced");

  property p_blocked_hold;
    @(posedge sck) disable iff (cs_n)
      blocked_reg && state_reg == ST_WDATA |-> !mem_we ##1
        addr_reg == $past(addr_reg);
  endproperty
  a_blocked_hold: assert property (p_blocked_hold)
    else $error("blocked burst still writing");

  property p_enable_sets;
    @(posedge clk) disable iff (rst) ev[FWP_EV_WR_ENABLE] |=> we_flag_reg;
  endproperty
  a_enable_sets: assert property (p_enable_sets)
    else $error("enable opcode did not set latch");

  property p_end_clears;
    @(posedge clk) disable iff (rst)
      cs_rise && arm_reg && !ev[FWP_EV_WR_ENABLE] |=> !we_flag_reg;
  endproperty
  a_end_clears: assert property (p_end_clears)
    else $error("latch not cleared at frame end");

  property p_ignore_quiet;
    @(negedge sck) disable iff (cs_n)
      state_reg == ST_IGNORE |-> ##1 !so_oe_reg;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet)
    else $error("output driven after unknown opcode");

endmodule
`default_nettype wire

// [dv/fwp_spi_master.sv]
// Partner model: serial bus master facing the protected memory
`timescale 1ns/100ps
`default_nettype none
module fwp_spi_master (
  // Serial link
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  input wire logic so,
  input wire logic so_oe
);
  // ****************
  // Frame control
  // ****************
  localparam real HALF = 62.5;
  logic mode3;
  initial begin
    mode3 = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Clock stands at its idle level outside frames
  task automatic cs_lo();
    sck = mode3;
    #(HALF);
    cs_n = 1'b0;
    #(HALF);
  endtask
  // Long gap lets latch clears settle before the next frame
  task automatic cs_hi();
    if (!mode3) begin
      sck = 1'b0;
    end
    #(HALF);
    cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
  // Shift nb bits, sample the resolved output on rising edges
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      input int nb = 8);
    rx = 8'hXX;
    for (int i = 7; i >= 8 - nb; i--) begin
      sck = 1'b0;
      si = tx[i];
      #(HALF);
      sck = 1'b1;
      rx[i] = so_oe ? so : 1'bz;
      #(HALF);
    end
  endtask
endmodule
`default_nettype wire

// [dv/tb_fwp_core.sv]
// Testbench of the serial protected memory
`timescale 1ns/100ps
`default_nettype none
module tb_fwp_core;
  import fwp_pkg::*;
  // ****************
  // Signals and instances
  // ****************
  logic clk, rst, wp_n, sck, cs_n, si, so, so_oe;
  int failures, checks_done;
  logic [7:0] exp_mem [int];
  logic [7:0] rx;
  logic [7:0] q [$];
  logic [1:0] b;
  initial clk = 1'b0;
  always #4 clk = ~clk;
  fwp_core u_dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
                  .so(so), .so_oe(so_oe), .wp_n(wp_n));
  fwp_spi_master u_master (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
                           .so_oe(so_oe));
  // ****************
  // Compare and verdict
  // ****************
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: so_oe %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************
  // Link operations
  // ****************
  task automatic cmd(input logic [7:0] op);
    u_master.cs_lo();
    u_master.xfer(op, rx);
    u_master.cs_hi();
  endtask
  task automatic stat(input logic [7:0] exp);
    u_master.cs_lo();
    u_master.xfer(FWP_OP_SR_READ, rx);
    u_master.xfer(8'h00, rx);
    cmp_byte(rx, exp);
    u_master.cs_hi();
    cmp_bit(so_oe, 1'b0);
  endtask
  task automatic swr(input logic [7:0] v);
    cmd(FWP_OP_WR_ENABLE);
    u_master.cs_lo();
    u_master.xfer(FWP_OP_SR_WRITE, rx);
    u_master.xfer(v, rx);
    u_master.cs_hi();
  endtask
  task automatic set_wp(input logic v);
    @(posedge clk);
    wp_n <= v;
  endtask
  function automatic logic prot(input logic [1:0] p, input logic [18:0] a);
    prot = (p == 2'h3) || (p == 2'h2 && a >= 19'h40000) ||
           (p == 2'h1 && a >= 19'h60000);
  endfunction
  // Burst of q with a trailing partial byte; top address bits set
  task automatic wr(input logic [18:0] a, input logic we,
                    input logic [1:0] p);
    logic stop;
    stop = !we;
    u_master.cs_lo();
    u_master.xfer(FWP_OP_WRITE, rx);
    u_master.xfer({5'h1F, a[18:16]}, rx);
    u_master.xfer(a[15:8], rx);
    u_master.xfer(a[7:0], rx);
    foreach (q[i]) begin
      u_master.xfer(q[i], rx);
      stop = stop || prot(p, a);
      if (!stop) begin
        exp_mem[a] = q[i];
        a = a + 19'h1;
      end
    end
    u_master.xfer(8'hFF, rx, 5);
    u_master.cs_hi();
  endtask
  // Serial input held high throughout the data phase
  task automatic rd(input logic [18:0] a, input int n);
    u_master.cs_lo();
    u_master.xfer(FWP_OP_READ, rx);
    u_master.xfer({5'h1F, a[18:16]}, rx);
    u_master.xfer(a[15:8], rx);
    u_master.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      u_master.xfer(8'hFF, rx);
      cmp_byte(rx, exp_mem[a]);
      a = a + 19'h1;
    end
    cmp_bit(so_oe, 1'b1);
    u_master.cs_hi();
    cmp_bit(so_oe, 1'b0);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    stat(8'h40);
    cmd(FWP_OP_WR_ENABLE);
    stat(8'h42);
    cmd(FWP_OP_WR_DISABLE);
    stat(8'h40);
    q = '{8'h5A};
    cmd(FWP_OP_WR_ENABLE);
    wr(19'h00001, 1'b1, 2'h0);
    stat(8'h40);
    q = '{8'h22, 8'h33};
    cmd(FWP_OP_WR_ENABLE);
    wr(19'h7FFFF, 1'b1, 2'h0);
    rd(19'h7FFFF, 3);
    q = '{8'h77};
    cmd(FWP_OP_WR_ENABLE);
    cmd(FWP_OP_WR_DISABLE);
    wr(19'h00000, 1'b0, 2'h0);
    rd(19'h00000, 2);
    swr(8'hFF);
    stat(8'hCC);
    set_wp(1'b0);
    swr(8'h00);
    stat(8'hCC);
    set_wp(1'b1);
    swr(8'h80);
    stat(8'hC0);
    set_wp(1'b0);
    q = '{8'h99};
    cmd(FWP_OP_WR_ENABLE);
    wr(19'h00000, 1'b1, 2'h0);
    rd(19'h00000, 1);
    set_wp(1'b1);
    swr(8'h00);
    set_wp(1'b0);
    swr(8'h04);
    stat(8'h44);
    set_wp(1'b1);
    for (int c = 0; c < 4; c++) begin
      b = c[1:0];
      swr({4'h0, b, 2'h0});
      stat({4'h4, b, 2'h0});
      q = '{8'(8'h10 + c), 8'(8'h20 + c)};
      cmd(FWP_OP_WR_ENABLE);
      wr(19'h3FFFF, 1'b1, b);
      q = '{8'(8'h30 + c), 8'(8'h40 + c)};
      cmd(FWP_OP_WR_ENABLE);
      wr(19'h5FFFF, 1'b1, b);
      rd(19'h3FFFF, 2);
      rd(19'h5FFFF, 2);
    end
    // Mid-run reset: latch drops, block bits are kept
    cmd(FWP_OP_WR_ENABLE);
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    stat(8'h4C);
    u_master.cs_lo();
    u_master.xfer(8'hAB, rx);
    u_master.xfer(FWP_OP_SR_READ, rx);
    u_master.xfer(8'h00, rx);
    cmp_bit(so_oe, 1'b0);
    u_master.cs_hi();
    u_master.mode3 = 1'b1;
    stat(8'h4C);
    u_master.mode3 = 1'b0;
    print_verdict();
  end
  // Hang guard, nearly three times the length of the run
  initial begin
    #700000;
    failures++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
